// ---- trigger_readout_regs.vh ----
// Purpose: constants for the trigger readout port
// Assumes: clk is the system synchronous clock at 125 MHz (8 ns)
// Notes: no software registers; all figures here are timing, size and field values
// Behaviour
// [R1] the 32-bit space is only the window onto the event fifo
// [R2] fifo readable by single-cycle and block transfer cycles
// [R3] 2eSST readout passes a token so one DMA drains all modules
// [R4] 24-bit space holds board registers and refuses block cycles
// [R5] trigger logic runs from the system synchronous clock
// [R6] both accept triggers sampled on the clock; assertion stores an event
// [R7] sync input aligns and restarts the board timers
// [R8] busy stays low normally and goes high when buffers near full
// [R9] supervisor stops triggers while busy is high
// [R10] token in and token out used only in 2eSST token transfers
// [R11] event building tolerates trigger latency up to 8 us
// [R12] capture path keeps up with trigger rates above 200 kHz
// [R13] token readout waits for token in, then raises token out when drained
`ifndef TRIGGER_READOUT_REGS_VH
`define TRIGGER_READOUT_REGS_VH
`define CLK_PERIOD_PS 8000
`define LATENCY_MAX_NS 8000
`define LATENCY_CYCLES ((`LATENCY_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define MIN_TRIG_RATE_KHZ 200
`define TRIG_SPACING_CYCLES ((1000000000 / `MIN_TRIG_RATE_KHZ) / `CLK_PERIOD_PS)
`define FIFO_DEPTH_LOG2 9
`define BUSY_MARGIN 16
`define TIMER_W 48
`define WORD_NOT_VALID 32'hf0000000
`define WORD_TRIG_A_BIT 29
`define WORD_TRIG_B_BIT 30
`define WORD_DEFINE_BIT 31
`define STATUS_BUSY_BIT 31
`define STATUS_OVF_BIT 30
`endif

// ---- trigger_readout_port.v ----
// Purpose: backplane readout port and trigger capture of a trigger module
// Assumes: bus requests arrive as one-cycle strobes decoded upstream into space and cycle type
// Notes: each accepted trigger writes one 32-bit word with its sources and corrected time
//   refused reads still answer with an error pulse, so no master stalls on this slot
`timescale 1ns/100ps
`include "trigger_readout_regs.vh"
module trigger_readout_port #(
  parameter DEPTH_LOG2 = `FIFO_DEPTH_LOG2,
  parameter BUSY_MARGIN = `BUSY_MARGIN,
  parameter LATENCY = `LATENCY_CYCLES
) (
  input wire clk,
  input wire nrst,
  input wire accept_trigger_a,
  input wire accept_trigger_b,
  input wire sync_in,
  input wire bus_strobe,
  input wire bus_space32,
  input wire bus_block,
  input wire bus_sst,
  input wire token_in,
  output reg bus_ack_q,
  output reg bus_err_q,
  output reg [31:0] bus_data_q,
  output reg busy_q,
  output reg overflow_q,
  output reg token_out_q
);
  // derived sizes; each constant is cut or extended on purpose to the width it meets
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam integer BUSY_FILL = DEPTH - BUSY_MARGIN;
  localparam [DEPTH_LOG2:0] BUSY_LEVEL = BUSY_FILL[DEPTH_LOG2:0];
  localparam [31:0] LAT_32 = LATENCY;
  localparam [`TIMER_W-1:0] LAT_W = {{(`TIMER_W-32){1'b0}}, LAT_32};
  // token states, one-hot
  localparam [2:0] TK_IDLE = 3'b001;
  localparam [2:0] TK_OWN = 3'b010;
  localparam [2:0] TK_PASS = 3'b100;

  // event storage; the pointers carry one extra bit so full and empty differ
  reg [31:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wr_q;
  reg [DEPTH_LOG2:0] rd_q;
  // board timer and the registered trigger-side pins
  reg [`TIMER_W-1:0] timer_q;
  reg trig_a_q;
  reg trig_b_q;
  reg sync_q;
  reg [2:0] tk_q;
  reg [2:0] tk_d;

  // pack one event word from its sources and time; bit positions live in the header
  function [31:0] event_word;
    input src_a;
    input src_b;
    input [28:0] stamp;
    begin
      event_word = {3'b000, stamp};
      event_word[`WORD_DEFINE_BIT] = 1'b1;
      event_word[`WORD_TRIG_B_BIT] = src_b;
      event_word[`WORD_TRIG_A_BIT] = src_a;
    end
  endfunction

  // status word of the board space: busy and overflow flags over the fill level
  function [31:0] status_word;
    input busy;
    input ovf;
    input [DEPTH_LOG2:0] fill;
    begin
      status_word = {{(31-DEPTH_LOG2){1'b0}}, fill};
      status_word[`STATUS_BUSY_BIT] = busy;
      status_word[`STATUS_OVF_BIT] = ovf;
    end
  endfunction

  // a fifo window hit is a strobe in the 32-bit space; used by the answer and the token
  function fifo_hit;
    input strobe;
    input space32;
    begin
      fifo_hit = strobe & space32;
    end
  endfunction

  // fifo fill bookkeeping
  wire [DEPTH_LOG2:0] level = wr_q - rd_q;
  wire empty = (level == {(DEPTH_LOG2+1){1'b0}});
  wire full = level[DEPTH_LOG2];
  wire trig_any = trig_a_q | trig_b_q;
  // a trigger is stored unless the fifo is full; a read pops only real words
  wire push = trig_any & ~full;
  // the timer is sampled when the trigger arrives, which is up to the latency after the event
  wire [`TIMER_W-1:0] ev_time = timer_q - LAT_W;
  wire is_fifo = fifo_hit(bus_strobe, bus_space32);
  wire tok_cycle = bus_sst & bus_block;
  // a token cycle may only read while this module holds the token
  wire fifo_ok = is_fifo & (~tok_cycle | (tk_q == TK_OWN));
  wire pop = fifo_ok & ~empty;

  // register the trigger-side pins on the system clock
  // no synchroniser: the pins already share this clock, so one stage is enough
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trig_a_q <= 1'b0;
      trig_b_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      trig_a_q <= accept_trigger_a; // [R5] [R6]
      trig_b_q <= accept_trigger_b; // [R6]
      sync_q <= sync_in; // [R7]
    end
  end

  // board timer restarts from zero on sync so all boards count in lockstep
  // at 48 bits the timer cannot wrap within any realistic run
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      timer_q <= {`TIMER_W{1'b0}};
    else if (sync_q)
      timer_q <= {`TIMER_W{1'b0}}; // [R7]
    else
      timer_q <= timer_q + {{(`TIMER_W-1){1'b0}}, 1'b1};
  end

  // one word per trigger every cycle keeps up far above the trigger rate
  // the array has no reset: only words below the write pointer are ever read
  always @(posedge clk) begin
    if (push)
      mem[wr_q[DEPTH_LOG2-1:0]] <= event_word(trig_a_q, trig_b_q, ev_time[28:0]); // [R6] [R11] [R12]
  end

  // pointers; a trigger landing on a full fifo is dropped and flagged
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= {(DEPTH_LOG2+1){1'b0}};
      rd_q <= {(DEPTH_LOG2+1){1'b0}};
      overflow_q <= 1'b0;
    end else begin
      if (push)
        wr_q <= wr_q + {{DEPTH_LOG2{1'b0}}, 1'b1}; // [R12]
      if (pop)
        rd_q <= rd_q + {{DEPTH_LOG2{1'b0}}, 1'b1}; // [R2]
      // sticky until reset, so a later drain never hides a lost event
      if (trig_any & full)
        overflow_q <= 1'b1;
    end
  end

  // busy warns with a margin so triggers already in flight still fit
  // a supervisor that ignores busy sees overflow set rather than damaged words
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      busy_q <= 1'b0;
    else
      busy_q <= (level >= BUSY_LEVEL); // [R8] [R9]
  end

  // token sequencing for chained 2eSST readout
  always @* begin
    tk_d = tk_q;
    case (tk_q)
      TK_IDLE: begin
        if (token_in)
          tk_d = TK_OWN; // [R13]
      end
      TK_OWN: begin
        // losing the token input at any point returns the port to idle
        if (!token_in)
          tk_d = TK_IDLE;
        else if (empty & fifo_hit(bus_strobe, bus_space32) & tok_cycle)
          tk_d = TK_PASS; // [R3] [R13]
      end
      TK_PASS: begin
        if (!token_in)
          tk_d = TK_IDLE;
      end
      default: tk_d = TK_IDLE;
    endcase
  end

  // token out follows the next state, so it rises with the answer to the token read that finds the fifo empty
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tk_q <= TK_IDLE;
      token_out_q <= 1'b0;
    end else begin
      tk_q <= tk_d;
      token_out_q <= (tk_d == TK_PASS); // [R10] [R13]
    end
  end

  // bus answer one cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_ack_q <= 1'b0;
      bus_err_q <= 1'b0;
      bus_data_q <= 32'h00000000;
    end else begin
      bus_ack_q <= 1'b0;
      bus_err_q <= 1'b0;
      if (bus_strobe) begin
        if (bus_space32) begin
          if (fifo_ok) begin
            bus_ack_q <= 1'b1; // [R1] [R2]
            bus_data_q <= empty ? `WORD_NOT_VALID : mem[rd_q[DEPTH_LOG2-1:0]];
          end else begin
            // a token cycle without the token is refused but still answered
            bus_err_q <= 1'b1; // [R13]
            bus_data_q <= 32'h00000000;
          end
        end else if (bus_block) begin
          // block cycles have no meaning in the board space
          bus_err_q <= 1'b1; // [R4]
          bus_data_q <= 32'h00000000;
        end else begin
          bus_ack_q <= 1'b1; // [R4]
          // single board reads return the status word in place of a register map
          bus_data_q <= status_word(busy_q, overflow_q, level);
        end
      end
    end
  end
endmodule

// ---- trigger_readout_port_sva.sv ----
// Purpose: port checks
// Assumes: one clock
// Notes: timer is not visible here
`timescale 1ns/100ps
module trp_chk (
  input wire clk,
  input wire nrst,
  input wire accept_trigger_a,
  input wire accept_trigger_b,
  input wire bus_strobe,
  input wire bus_space32,
  input wire bus_block,
  input wire bus_sst,
  input wire token_in,
  input wire bus_ack_q,
  input wire bus_err_q,
  input wire [31:0] bus_data_q,
  input wire busy_q,
  input wire token_out_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_ans_once: assert property (bus_strobe |=> bus_ack_q ^ bus_err_q)
    else $error("no reply");
  chk_ans_cause: assert property (!bus_strobe |=> !bus_ack_q && !bus_err_q)
    else $error("stray reply");
  chk_blk_refused: assert property (bus_strobe && !bus_space32 && bus_block |=> bus_err_q)
    else $error("block taken");
  chk_fifo_ack: assert property (bus_strobe && bus_space32 && !bus_sst |=> bus_ack_q)
    else $error("fifo refused");
  chk_word_tag: assert property (bus_strobe && bus_space32 |=> !bus_ack_q || bus_data_q[31])
    else $error("bad tag");
  chk_tok_drop: assert property (!token_in |=> !token_out_q)
    else $error("token kept");
  chk_tok_cause: assert property ($rose(token_out_q) |-> $past(token_in))
    else $error("stray token");
  chk_busy_src: assert property ($rose(busy_q) |-> $past(accept_trigger_a | accept_trigger_b, 3))
    else $error("stray busy");
endmodule
bind trigger_readout_port trp_chk u_chk (
  .clk(clk),
  .nrst(nrst),
  .accept_trigger_a(accept_trigger_a),
  .accept_trigger_b(accept_trigger_b),
  .bus_strobe(bus_strobe),
  .bus_space32(bus_space32),
  .bus_block(bus_block),
  .bus_sst(bus_sst),
  .token_in(token_in),
  .bus_ack_q(bus_ack_q),
  .bus_err_q(bus_err_q),
  .bus_data_q(bus_data_q),
  .busy_q(busy_q),
  .token_out_q(token_out_q)
);

// ---- trig_supervisor.sv ----
// Purpose: trigger supervisor model
// Assumes: triggers launched on the falling edge
// Notes: a 4-cycle gap lets busy arrive before the next trigger
`timescale 1ns/100ps
module trig_supervisor (
  input wire clk,
  input wire run,
  input wire busy_q,
  output reg accept_trigger_a = 1'b0,
  output reg accept_trigger_b = 1'b0
);
  reg [1:0] gap_q = 2'h0;
  // hold off while busy; busy lags a trigger by three edges
  always @(negedge clk) begin
    gap_q <= gap_q + 2'h1;
    accept_trigger_a <= run && !busy_q && gap_q == 2'h0 && $urandom % 2;
    accept_trigger_b <= run && !busy_q && gap_q == 2'h0 && $urandom % 2;
  end
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench of the readout port
// Assumes: 16-word fifo so busy is reached fast
// Notes: word times are reckoned from the sync pulse, less the trigger latency
`timescale 1ns/100ps
`include "trigger_readout_regs.vh"
module testbench;
  reg clk = 1'b0, nrst = 1'b0, run = 1'b0, stb = 1'b0, s32 = 1'b0, blk = 1'b0, sst = 1'b0;
  reg tok = 1'b0;
  reg sync = 1'b0;
  wire ta, tb, ack, err, busy, ovf, tout;
  wire [31:0] data;
  int n_errors = 0, n_tests = 0, cyc = 0, sync_cyc = 0, q[$];
  logic [31:0] w, e;
  logic [28:0] t;
  initial forever #4 clk = ~clk;
  // reference queue of triggers seen at the pins
  always @(posedge clk) begin
    cyc++;
    if (sync) sync_cyc = cyc;
    if (ta | tb) q.push_back({tb, ta, cyc[28:0]});
  end
  trig_supervisor i_sup (.clk(clk), .run(run), .busy_q(busy), .accept_trigger_a(ta),
    .accept_trigger_b(tb));
  trigger_readout_port #(.DEPTH_LOG2(4), .BUSY_MARGIN(2)) i_dut (.clk(clk), .nrst(nrst),
    .accept_trigger_a(ta), .accept_trigger_b(tb), .sync_in(sync), .bus_strobe(stb),
    .bus_space32(s32), .bus_block(blk), .bus_sst(sst), .token_in(tok), .bus_ack_q(ack),
    .bus_err_q(err), .bus_data_q(data), .busy_q(busy), .overflow_q(ovf), .token_out_q(tout));
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; the answer stands only in the cycle after the taking edge
  task rd(input logic sp, bk, ss, input logic [1:0] rsp, output logic [31:0] d);
    @(negedge clk);
    {stb, s32, blk, sst} = {1'b1, sp, bk, ss};
    @(negedge clk);
    d = data;
    check({err, ack}, rsp);
    stb = 1'b0;
  endtask
  task report_and_stop;
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(59316));
    repeat (6) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    @(negedge clk) sync = 1'b1;
    @(negedge clk) sync = 1'b0;
    run = 1'b1;
    repeat (120) @(negedge clk);
    run = 1'b0;
    repeat (4) @(negedge clk);
    rd(0, 0, 0, 2'h1, w);
    check(w, {q.size() >= 14, 1'b0, 20'h0, 10'(q.size())});
    check(ovf, 1'b0);
    rd(0, 1, 0, 2'h2, w);
    rd(1, 1, 1, 2'h2, w);
    @(negedge clk) tok = 1'b1;
    // drain with reads picked by the low time bits; triggers come every 4 cycles, so each is a single read with sst set and no block
    while (q.size()) begin
      e = q.pop_front();
      rd(1, e[0], e[1], 2'h1, w);
      t = 29'(e[28:0] - sync_cyc - 1 - `LATENCY_CYCLES);
      check(w, {1'b1, e[30:29], t});
    end
    rd(1, 0, 0, 2'h1, w);
    check(w, 32'hf0000000);
    rd(1, 1, 1, 2'h1, w);
    check(w, 32'hf0000000);
    @(posedge clk) #1 check(tout, 1'b1);
    @(negedge clk) tok = 1'b0;
    @(posedge clk) #1 check(tout, 1'b0);
    report_and_stop;
  end
endmodule
